// file: sdf_buf.sv
// Two-entry valid/ready buffer for output words
`timescale 1ns/1ps
module sdf_buf
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [OUT_W-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [OUT_W-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    typedef struct packed
    {
        logic [BUF_DEPTH-1:0][OUT_W-1:0] mem;
        logic [1:0]                      cnt;
        logic                            vld;
    } sdf_buf_s;

    sdf_buf_s st_q;
    sdf_buf_s st_d;
    logic     push;
    logic     pop;

    // Head is always entry 0; a pop shifts entry 1 down
    always_comb
    begin
        st_d = st_q;
        pop  = out_ready_in && (st_q.cnt != 2'h0);
        // A pop frees the head in the same cycle, so a full buffer that is
        // being drained still takes the incoming word instead of losing it
        push = in_valid_in && ((st_q.cnt != 2'(BUF_DEPTH)) || pop);
        if (pop)
        begin
            st_d.mem[0] = st_q.mem[1];
        end
        if (push)
        begin
            st_d.mem[2'(st_q.cnt) - 2'(pop)] = in_data_in;
        end
        st_d.cnt = st_q.cnt + 2'(push) - 2'(pop);
        if (!rst_n_in)
        begin
            st_d.cnt = 2'h0;
        end
        // Valid is kept in its own flop so the output needs no decode
        st_d.vld = st_d.cnt != 2'h0;
    end

    always_ff @(posedge clk_in)
    begin
        st_q <= st_d;
    end

    assign in_ready_out  = (st_q.cnt != 2'(BUF_DEPTH)) || out_ready_in;
    assign out_valid_out = st_q.vld;
    assign out_data_out  = st_q.mem[0];
endmodule // sdf_buf

// file: sdf_host.sv
// Host-side sinc3 decimation filter for a 1-bit sigma-delta modulator
// What this block does
// - Low bit counts zero, high bit one
// - Three cascaded 24-bit integrators per bit
// - Reset clears all three integrators
// - 8-bit decimation counter steps at falling edge
// - Word strobe is counter bit seven
// - Three differentiators update at strobe rise
// - Reset clears differentiators and delayed copies
// - Output word is third differentiator bits 23:8
// - Overall response is third-order sinc
// - Bit sampled at falling clock edge
`timescale 1ns/1ps
module sdf_host
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Modulator link
    input  wire logic             modulator_bitstream_in,
    output logic                  modulator_clock_in_out,
    // Filtered word stream
    output logic                  word_valid_out,
    output logic [OUT_W-1:0]      word_data_out,
    input  wire logic             word_ready_in,
    // Status
    output logic                  word_dropped_out
);
    typedef struct packed
    {
        logic [3:0]       div;
        logic             bclk;
        logic [ACC_W-1:0] integ1;
        logic [ACC_W-1:0] integ2;
        logic [ACC_W-1:0] third_integrator;
        logic [CNT_W-1:0] dec_cnt;
        logic             strobe_prev;
        logic [ACC_W-1:0] integ3_held;
        logic [ACC_W-1:0] diff1;
        logic [ACC_W-1:0] diff2;
        logic [ACC_W-1:0] third_differentiator;
        logic [ACC_W-1:0] diff1_held;
        logic [ACC_W-1:0] diff2_held;
        logic [OUT_W-1:0] word;
        logic             word_new;
        logic             dropped;
        logic             bit_sample;
    } sdf_host_s;

    sdf_host_s  st_q;
    sdf_host_s  st_d;
    logic       bit_sync;
    logic       buf_ready;
    logic       buf_valid;
    logic [OUT_W-1:0] buf_data;
    sdf_phase_e phase;
    logic [ACC_W-1:0] sample;
    logic       strobe_now;

    // Returns the numeric sample for one modulator bit
    function automatic logic [ACC_W-1:0] bit_to_sample(input logic b);
        return b ? SAMPLE_ONE : SAMPLE_ZERO;
    endfunction

    // Bitstream pin crosses into the system clock through two flops
    sdf_sync u_sync
    (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in (modulator_bitstream_in),
        .sync_out (bit_sync)
    );

    // Phase of the generated bit clock for this cycle
    always_comb
    begin
        if (st_q.div == DIV_LAST)
        begin
            phase = st_q.bclk ? SDF_FALL : SDF_RISE;
        end
        else
        begin
            phase = st_q.bclk ? SDF_HIGH : SDF_LOW;
        end
    end

    // Next state: divider, integrators, decimator, differentiators
    always_comb
    begin
        st_d       = st_q;
        sample     = bit_to_sample(st_q.bit_sample);
        strobe_now = st_q.dec_cnt[STROBE_BIT];
        st_d.word_new = 1'b0;

        // Clock divider makes the modulator clock; the modulator then puts
        // out one bit per period
        if (st_q.div == DIV_LAST)
        begin
            st_d.div  = 4'h0;
            st_d.bclk = ~st_q.bclk;
        end
        else
        begin
            st_d.div = st_q.div + 4'h1;
        end

        unique case (phase)
            SDF_FALL:
            begin
                // Take the bit at the falling edge, a half period after
                // the modulator launched it, so the sync delay is covered
                st_d.bit_sample = bit_sync;
                st_d.dec_cnt    = st_q.dec_cnt + CNT_STEP;
            end
            SDF_RISE:
            begin
                // Modulo 2^24 wrap lets integrator overflow cancel later
                st_d.integ1           = st_q.integ1 + sample;
                st_d.integ2           = st_q.integ2 + st_q.integ1;
                st_d.third_integrator = st_q.third_integrator + st_q.integ2;
            end
            SDF_LOW, SDF_HIGH:
            begin
                st_d.bit_sample = st_q.bit_sample;
            end
        endcase

        // Comb section runs once per word, at the strobe's rising edge
        st_d.strobe_prev = strobe_now;
        if (strobe_now && !st_q.strobe_prev)
        begin
            st_d.diff1 = st_q.third_integrator - st_q.integ3_held;
            st_d.diff2 = st_q.diff1 - st_q.diff1_held;
            st_d.third_differentiator = st_q.diff2 - st_q.diff2_held;
            st_d.integ3_held = st_q.third_integrator;
            st_d.diff1_held  = st_q.diff1;
            st_d.diff2_held  = st_q.diff2;
            st_d.word        = st_q.third_differentiator[ACC_W-1:OUT_LSB];
            st_d.word_new    = 1'b1;
        end

        // A word that meets a full buffer is lost; flag it until reset
        if (st_q.word_new && !buf_ready)
        begin
            st_d.dropped = 1'b1;
        end

        // Reset clears counter and arithmetic but not the output word
        if (!rst_n_in)
        begin
            st_d.div              = 4'h0;
            st_d.bclk             = 1'b0;
            st_d.integ1           = ACC_CLEAR;
            st_d.integ2           = ACC_CLEAR;
            st_d.third_integrator = ACC_CLEAR;
            st_d.dec_cnt          = CNT_CLEAR;
            st_d.strobe_prev      = 1'b0;
            st_d.integ3_held      = ACC_CLEAR;
            st_d.diff1            = ACC_CLEAR;
            st_d.diff2            = ACC_CLEAR;
            st_d.third_differentiator = ACC_CLEAR;
            st_d.diff1_held       = ACC_CLEAR;
            st_d.diff2_held       = ACC_CLEAR;
            st_d.word_new         = 1'b0;
            st_d.dropped          = 1'b0;
            st_d.bit_sample       = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        st_q <= st_d;
    end

    // Buffer absorbs a stalled consumer for up to two words
    sdf_buf u_buf
    (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (st_q.word_new),
        .in_data_in    (st_q.word),
        .in_ready_out  (buf_ready),
        .out_valid_out (buf_valid),
        .out_data_out  (buf_data),
        .out_ready_in  (word_ready_in)
    );

    assign modulator_clock_in_out = st_q.bclk;
    assign word_valid_out         = buf_valid;
    assign word_data_out          = buf_data;
    assign word_dropped_out       = st_q.dropped;
endmodule // sdf_host

// file: sdf_host_properties.sv
// Checker: port-level properties of the sinc3 filter host
`timescale 1ns/1ps
module sdf_host_properties
    import sdf_pkg::*;
(
    // Clock and reset
    input wire logic             clk_in,
    input wire logic             rst_n_in,
    // Modulator link
    input wire logic             modulator_bitstream_in,
    input wire logic             modulator_clock_in_out,
    // Word stream and status
    input wire logic             word_valid_out,
    input wire logic [OUT_W-1:0] word_data_out,
    input wire logic             word_ready_in,
    input wire logic             word_dropped_out
);
    wire        mc = modulator_clock_in_out;
    logic       mc_q;
    logic [7:0] fall_cnt_q;

    // Mirror of the decimation counter, so entry timing can be checked from the pins
    always_ff @(posedge clk_in)
    begin
        mc_q <= mc;
        if (!rst_n_in)
            fall_cnt_q <= 8'h00;
        else if (mc_q && !mc)
            fall_cnt_q <= fall_cnt_q + 8'h01;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_bclk_high_len: assert property (
        $rose(mc) |-> mc[*8] ##1 !mc) else $error("bit clock high phase wrong");
    a_bclk_low_len: assert property (
        $fell(mc) |-> !mc[*8] ##1 mc) else $error("bit clock low phase wrong");
    a_word_entry_phase: assert property (
        $rose(word_valid_out) |-> fall_cnt_q == 8'h80 && !mc) else $error("word at wrong count");
    a_entry_bclk_low: assert property (
        $rose(word_valid_out) |-> !mc[*5]) else $error("word entry off the falling phase");
    a_word_hold: assert property (
        word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_data_out))
        else $error("word changed while stalled");
    a_drop_sticky: assert property (
        word_dropped_out |=> word_dropped_out) else $error("drop flag cleared");
    a_drop_entry: assert property (
        $rose(word_dropped_out) |-> fall_cnt_q == 8'h80 && word_valid_out)
        else $error("drop away from word entry");
    a_drop_full: assert property (
        $rose(word_dropped_out) |-> $past(word_valid_out, 2) && !$past(word_ready_in))
        else $error("drop without full buffer");
endmodule // sdf_host_properties

bind sdf_host sdf_host_properties u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .modulator_bitstream_in(modulator_bitstream_in),
    .modulator_clock_in_out(modulator_clock_in_out), .word_valid_out(word_valid_out),
    .word_data_out(word_data_out), .word_ready_in(word_ready_in),
    .word_dropped_out(word_dropped_out));

// file: sdf_mod_model.sv
// Behavioural modulator: periodic density-of-ones source clocked by the host
`timescale 1ns/1ps
module sdf_mod_model
    import sdf_pkg::*;
(
    // Bit clock from the host
    input  wire logic       bit_clk_in,
    // Ones per 256 bits, or strict alternation
    input  wire logic [8:0] ones_in,
    input  wire logic       alt_in,
    // Bitstream to the host
    output logic            bit_out
);
    logic [7:0] phase_q = 8'h00;

    // Bit moves just after the rise, so the falling-edge sample sees it settled
    always @(posedge bit_clk_in)
    begin
        phase_q <= phase_q + 8'h01;
        bit_out <= #1 alt_in ? phase_q[0] : ({1'b0, phase_q} < ones_in);
    end
endmodule // sdf_mod_model

// file: sdf_pkg.sv
// Package: constants and types for the sinc3 decimation filter host
package sdf_pkg;
    localparam int          ACC_W        = 24;            // Integrator / differentiator width
    localparam int          OUT_W        = 16;            // Output word width
    localparam int          CNT_W        = 8;             // Decimation counter width
    localparam int          STROBE_BIT   = 7;             // Counter bit that forms the word strobe
    localparam int          OUT_LSB      = 8;             // Lowest third_differentiator bit kept
    localparam int          BUF_DEPTH    = 2;             // Output buffer depth
    localparam logic [23:0] SAMPLE_ONE   = 24'h000001;    // High bit maps to one
    localparam logic [23:0] SAMPLE_ZERO  = 24'h000000;    // Low bit maps to zero
    localparam logic [7:0]  CNT_STEP     = 8'h01;         // Decimation counter increment
    localparam logic [23:0] ACC_CLEAR    = 24'h000000;    // Arithmetic reset value
    localparam logic [7:0]  CNT_CLEAR    = 8'h00;         // Counter reset value
    localparam real         CLK_PERIOD_NS = 4.0;          // System clock period
    localparam real         DIV_HALF_NS   = 32.0;         // Half period of the generated bit clock
    localparam int          DIV_HALF_CYC  =
        (DIV_HALF_NS / CLK_PERIOD_NS) < 1.0 ? 1 : int'($floor(DIV_HALF_NS / CLK_PERIOD_NS));
    localparam logic [3:0]  DIV_LAST      = 4'(DIV_HALF_CYC - 1);

    // Bit clock edge phase of the host
    typedef enum logic [1:0] {
        SDF_LOW  = 2'b00,
        SDF_RISE = 2'b01,
        SDF_HIGH = 2'b11,
        SDF_FALL = 2'b10
    } sdf_phase_e;
endpackage : sdf_pkg

// file: sdf_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdf_sync
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Asynchronous level in, synchronous level out
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed
    {
        logic meta;
        logic sync;
    } sdf_sync_s;

    sdf_sync_s st_q;
    sdf_sync_s st_d;

    // First stage is read only by the second
    always_comb
    begin
        st_d.meta = async_in;
        st_d.sync = st_q.meta;
        if (!rst_n_in)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        st_q <= st_d;
    end

    assign sync_out = st_q.sync;
endmodule // sdf_sync

// file: tb.sv
// Testbench: sinc3 filter host against the modulator model
`timescale 1ns/1ps
module tb;
    import sdf_pkg::*;
    logic        clk, rst_n, mclk, mod_bit, valid, ready, dropped, alt;
    logic [15:0] data, w;
    logic [8:0]  ones, rk;
    int          mismatches, cmp_count, n;

    // Clock 250 MHz
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    sdf_host dut (.clk_in(clk), .rst_n_in(rst_n), .modulator_bitstream_in(mod_bit),
        .modulator_clock_in_out(mclk), .word_valid_out(valid), .word_data_out(data),
        .word_ready_in(ready), .word_dropped_out(dropped));
    sdf_mod_model u_mod (.bit_clk_in(mclk), .ones_in(ones), .alt_in(alt), .bit_out(mod_bit));

    // Any 256-bit window holds k ones; the cubed sum gives k*2^16, wrapping at 256
    function automatic logic [15:0] exp_word(input logic [8:0] k);
        return {k[7:0], 8'h00};
    endfunction

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic close_out;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Pop one word; the bound covers a word period with margin
    task automatic get_word(output logic [15:0] got);
        int k;
        k = 0;
        while (k < 6000 && !(valid === 1'b1 && ready === 1'b1))
        begin
            @(negedge clk);
            k++;
        end
        if (k == 6000)
            mismatches++;
        got = data;
        @(posedge clk);
        #1;
    endtask

    // The window the change lands in, three clean windows, then comb stages two and three
    // and the output register each add one word of lag: the seventh word is the first settled one
    task automatic run_k(input logic [8:0] k, input logic a);
        ones = k;
        alt = a;
        repeat (7) get_word(w);
    endtask

    initial
    begin
        void'($urandom(32'h85df));
        {mismatches, cmp_count} = '0;
        {rst_n, ready, alt} = 3'b010;
        ones = 9'h000;
        repeat (6) @(posedge clk);
        #1;
        chk(16'h0000, {13'h0000, mclk, valid, dropped});
        rst_n = 1'b1;
        rk = 9'($urandom_range(255, 1));
        run_k(rk, 1'b0);
        chk(exp_word(rk), w);
        run_k(9'h100, 1'b0);
        chk(exp_word(9'h100), w);
        run_k(9'h080, 1'b1);
        chk(exp_word(9'h080), w);
        // Stall until a third word meets the full buffer
        ready = 1'b0;
        n = 0;
        while (n < 14000 && dropped !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(16'h0003, {14'h0000, valid, dropped});
        ready = 1'b1;
        repeat (2)
        begin
            get_word(w);
            chk(16'h8000, w);
        end
        chk(16'h0001, {14'h0000, valid, dropped});
        close_out;
    end

    // Watchdog: about 105000 cycles, above the 24 word periods the tests need
    initial
    begin
        #420000;
        mismatches++;
        close_out;
    end
endmodule // tb
